// >>> verilog/cbf_pkg.sv
// package: shared constants, request carrier and state type of the bus-cycle sequencer
package cbf_pkg;

	// ----------------------------------------------------------------
	// bus widths and buffering
	// ----------------------------------------------------------------
	localparam int ADDR_W = 23; // word address, upper-order bits only
	localparam int DATA_W = 16; // data bus width
	localparam int FIFO_DEPTH = 8; // queued internal bus requests

	// ----------------------------------------------------------------
	// reset values of the registered pins
	// ----------------------------------------------------------------
	localparam logic ADS_N_RST = 1'b1; // strobe negated
	localparam logic OE_RST = 1'b0; // data bus floated
	localparam logic PHASE_RST = 1'b0; // phase one after reset
	localparam logic GRANT_RST = 1'b0; // no hold grant
	localparam logic [1:0] BE_N_RST = 2'h3; // both byte enables negated; unused, iss resets both byte enable pins to 0

	// ----------------------------------------------------------------
	// one internal bus request: address, cycle definition, write data
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr; // word address
		logic [1:0] be_n; // upper / lower byte enable, low active
		logic wr; // 1 write, 0 read
		logic dc; // 1 data, 0 control
		logic mio; // 1 memory, 0 i/o
		logic [DATA_W-1:0] wdata; // write data
	} cbf_req_t;

	localparam int REQ_W = $bits(cbf_req_t);

	// ----------------------------------------------------------------
	// bus states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE, // idle_state
		S_T1, // first_state
		S_T2, // second_state
		S_T1P, // pipelined_first_state
		S_T2P, // pipelined_pending_state
		S_T2I, // pipelined_idle_wait_state
		S_HOLD // hold_ack_state
	} cbf_state_t;

endpackage : cbf_pkg

// >>> verilog/cbf_bus_cycle.sv
// bus-cycle sequencer of a demultiplexed cpu bus, with its request fifo
// Function
// - t1 phase one: address, definition, strobe valid
// - ready ignored at end of t1
// - shortest cycle is t1 then t2
// - data bus floated during read cycles
// - read acknowledged in t2 captures data bus
// - write data driven from phase two of t1/t1p
// - write data held through next phase one
// - t2 repeats while not ready, no next-address
// - one t1, always followed by t2
// - after ack: t1 if pending, else idle
// - hold request enters hold state instead
// - address stable through nonpipelined wait states
// - nonpipelined after reset/idle; then per next-address
// - next-address sampled phase two, acted in waits
// - pipelined address and strobe issued before end
// - t1p entered when supplying cycle completes
// - t1p samples next-address; pending goes t2p if asserted, else t2
// - no pending request: t1p goes t2i
// - pipelined cycle ends in t2, t2p or t2i
// - pipelined read ack captures data bus
// - pipelining continues while next-address asserted
// - bus state is one or two clocks
// - t2p repeats while not ready; t2i, while not ready, repeats until a request is pending, then goes t2p
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// request fifo
// ----------------------------------------------------------------
module cbf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH]; // storage, written only on push
	logic [PW-1:0] wr_ptr; // next slot to fill
	logic [PW-1:0] rd_ptr; // head slot
	logic [CW-1:0] cnt; // words held
	logic in_ready; // registered so the source sees a clean flop
	logic [PW-1:0] next_wr_ptr;
	logic [PW-1:0] next_rd_ptr;
	logic [CW-1:0] next_cnt;
	logic next_in_ready;
	logic push;
	logic pop;

	assign in_ready_o = in_ready;
	assign out_valid_o = (cnt != '0);
	assign out_data_o = mem[rd_ptr];

	// pointer and count update; a full fifo refuses the source
	always_comb
	begin
		push = in_valid_i && in_ready;
		pop = out_ready_i && (cnt != '0);
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push)
		begin
			next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
		end
		if (pop)
		begin
			next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
		end
		next_cnt = cnt + CW'(push) - CW'(pop);
		next_in_ready = (next_cnt != FULL);
	end

	// state registers
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt <= '0;
			in_ready <= 1'b1;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			cnt <= next_cnt;
			in_ready <= next_in_ready;
		end
	end

	// storage has no reset; only filled slots are ever read
	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem[wr_ptr] <= in_data_i;
		end
	end
endmodule : cbf_fifo

// ----------------------------------------------------------------
// bus-cycle sequencer
// ----------------------------------------------------------------
module cbf_bus_cycle (
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic DOUBLED_MODE_I,
	input wire cbf_pkg::cbf_req_t REQ_I,
	input wire logic REQ_VALID_I,
	output logic REQ_READY_O,
	input wire logic READY_N_I,
	input wire logic NEXT_ADDRESS_REQUEST_N_I,
	input wire logic HOLD_I,
	input wire logic [15:0] DATA_BUS_I,
	output logic [15:0] DATA_BUS_O,
	output logic DATA_BUS_OE_O,
	output logic [22:0] WORD_ADDRESS_O,
	output logic UPPER_BYTE_ENABLE_N_O,
	output logic LOWER_BYTE_ENABLE_N_O,
	output logic WRITE_CYCLE_O,
	output logic DATA_CYCLE_O,
	output logic MEMORY_CYCLE_O,
	output logic ADDRESS_STROBE_N_O,
	output logic HOLD_GRANT_O,
	output logic [15:0] READ_DATA_O,
	output logic READ_DATA_VALID_O
);
	cbf_pkg::cbf_state_t st; // current bus state
	cbf_pkg::cbf_state_t next_st;
	cbf_pkg::cbf_req_t iss; // request whose address is on the pins
	cbf_pkg::cbf_req_t next_iss;
	cbf_pkg::cbf_req_t cur; // request whose data phase is running
	cbf_pkg::cbf_req_t next_cur;
	cbf_pkg::cbf_req_t f_data; // fifo head
	logic f_valid; // an internal request is pending
	logic pop; // take the head onto the address pins
	logic ph; // 0 phase one, 1 phase two
	logic next_ph;
	logic na_smp; // next-address request sampled at phase two
	logic next_na_smp;
	logic ads_n;
	logic next_ads_n;
	logic grant;
	logic next_grant;
	logic oe;
	logic next_oe;
	logic [15:0] dout;
	logic [15:0] next_dout;
	logic [15:0] rdata;
	logic [15:0] next_rdata;
	logic rvalid;
	logic next_rvalid;
	logic e1; // this edge ends phase one
	logic e2; // this edge ends the bus state
	logic rdy; // ready acknowledge at this edge
	logic na; // next-address request seen in this state
	logic done; // a data phase completes at this edge

	// ----------------------------------------------------------------
	// request buffer
	// ----------------------------------------------------------------
	cbf_fifo #(
		.WIDTH(cbf_pkg::REQ_W),
		.DEPTH(cbf_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(CLOCK_I),
		.rst_i(RST_I),
		.in_valid_i(REQ_VALID_I),
		.in_ready_o(REQ_READY_O),
		.in_data_i(REQ_I),
		.out_valid_o(f_valid),
		.out_ready_i(pop),
		.out_data_o(f_data)
	);

	// ----------------------------------------------------------------
	// phase tracking and next-address sampling
	// ----------------------------------------------------------------
	// doubled mode: one clock per state, both phase edges coincide
	always_comb
	begin
		e1 = DOUBLED_MODE_I || !ph;
		e2 = DOUBLED_MODE_I || ph;
		next_ph = !ph;
		next_na_smp = e1 ? !NEXT_ADDRESS_REQUEST_N_I : na_smp;
		na = DOUBLED_MODE_I ? !NEXT_ADDRESS_REQUEST_N_I : na_smp;
	end

	// phase one is aligned to the release of reset
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			ph <= cbf_pkg::PHASE_RST;
			na_smp <= 1'b0;
		end
		else
		begin
			ph <= next_ph;
			na_smp <= next_na_smp;
		end
	end

	// ----------------------------------------------------------------
	// bus state machine and pin registers
	// ----------------------------------------------------------------
	always_comb
	begin
		rdy = !READY_N_I;
		next_st = st;
		if (e2)
		begin
			unique case (st)
				cbf_pkg::S_IDLE:
				begin
					// hold wins over a pending request
					if (HOLD_I)
						next_st = cbf_pkg::S_HOLD;
					else if (f_valid)
						next_st = cbf_pkg::S_T1;
				end
				cbf_pkg::S_HOLD:
				begin
					// leaving hold always starts nonpipelined
					if (!HOLD_I)
						next_st = f_valid ? cbf_pkg::S_T1 : cbf_pkg::S_IDLE;
				end
				cbf_pkg::S_T1:
				begin
					// ready is not looked at here
					next_st = cbf_pkg::S_T2;
				end
				cbf_pkg::S_T2, cbf_pkg::S_T2I:
				begin
					if (rdy)
					begin
						if (HOLD_I)
							next_st = cbf_pkg::S_HOLD;
						else
							next_st = f_valid ? cbf_pkg::S_T1 : cbf_pkg::S_IDLE;
					end
					else if (st == cbf_pkg::S_T2I)
						next_st = f_valid ? cbf_pkg::S_T2P : cbf_pkg::S_T2I;
					else if (na)
						next_st = f_valid ? cbf_pkg::S_T2P : cbf_pkg::S_T2I;
					else
						next_st = cbf_pkg::S_T2;
				end
				cbf_pkg::S_T2P:
				begin
					// the next address is out, so hold waits for an ack in t2 or t2i
					next_st = rdy ? cbf_pkg::S_T1P : cbf_pkg::S_T2P;
				end
				cbf_pkg::S_T1P:
				begin
					// ready is ignored at the end of t1p
					if (!f_valid)
						next_st = cbf_pkg::S_T2I;
					else if (na)
						next_st = cbf_pkg::S_T2P;
					else
						next_st = cbf_pkg::S_T2;
				end
			endcase
		end

		// a new address goes out on entry to t1 or to t2p
		pop = e2 && ((next_st == cbf_pkg::S_T1)
			|| (next_st == cbf_pkg::S_T2P && st != cbf_pkg::S_T2P));
		next_iss = pop ? f_data : iss;
		next_cur = cur;
		if (e2 && next_st == cbf_pkg::S_T1)
			next_cur = f_data;
		else if (e2 && next_st == cbf_pkg::S_T1P)
			next_cur = iss;
		next_ads_n = !(next_st == cbf_pkg::S_T1 || next_st == cbf_pkg::S_T2P);
		next_grant = (next_st == cbf_pkg::S_HOLD);

		// data phase ends only in t2, t2i or t2p
		done = e2 && rdy && (st == cbf_pkg::S_T2 || st == cbf_pkg::S_T2I
			|| st == cbf_pkg::S_T2P);
		next_rvalid = done && !cur.wr;
		next_rdata = (done && !cur.wr) ? DATA_BUS_I : rdata;

		// drive decision is taken at the end of phase one from the old state,
		// so a just-acknowledged write stays on the bus through phase one
		next_oe = oe;
		next_dout = dout;
		if (e1)
		begin
			next_oe = cur.wr && (st == cbf_pkg::S_T1 || st == cbf_pkg::S_T2
				|| st == cbf_pkg::S_T1P || st == cbf_pkg::S_T2P
				|| st == cbf_pkg::S_T2I);
			next_dout = cur.wdata;
		end
	end

	// registers only
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			st <= cbf_pkg::S_IDLE;
			iss <= '0;
			cur <= '0;
			ads_n <= cbf_pkg::ADS_N_RST;
			grant <= cbf_pkg::GRANT_RST;
			oe <= cbf_pkg::OE_RST;
			dout <= '0;
			rdata <= '0;
			rvalid <= 1'b0;
		end
		else
		begin
			st <= next_st;
			iss <= next_iss;
			cur <= next_cur;
			ads_n <= next_ads_n;
			grant <= next_grant;
			oe <= next_oe;
			dout <= next_dout;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	assign WORD_ADDRESS_O = iss.addr;
	assign UPPER_BYTE_ENABLE_N_O = iss.be_n[1];
	assign LOWER_BYTE_ENABLE_N_O = iss.be_n[0];
	assign WRITE_CYCLE_O = iss.wr;
	assign DATA_CYCLE_O = iss.dc;
	assign MEMORY_CYCLE_O = iss.mio;
	assign ADDRESS_STROBE_N_O = ads_n;
	assign HOLD_GRANT_O = grant;
	assign DATA_BUS_O = dout;
	assign DATA_BUS_OE_O = oe;
	assign READ_DATA_O = rdata;
	assign READ_DATA_VALID_O = rvalid;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);

	AST_T1_STROBE:
		assert property (st == cbf_pkg::S_T1 |-> !ads_n && ($changed(st) || ph))
		else $error("t1 without strobe or repeated");
	AST_T1_TO_T2:
		assert property (st == cbf_pkg::S_T1 && e2 |=> st == cbf_pkg::S_T2)
		else $error("t1 not followed by t2");
	AST_SHORTEST:
		assert property (st == cbf_pkg::S_T2 && e2 && rdy && !HOLD_I |=>
			st == cbf_pkg::S_T1 || st == cbf_pkg::S_IDLE)
		else $error("acknowledged t2 did not end the cycle");
	AST_READ_FLOAT:
		assert property (st == cbf_pkg::S_T2 && !cur.wr |-> !oe)
		else $error("data bus driven in read");
	AST_READ_CAPTURE:
		assert property (done && !cur.wr |=> rvalid && rdata == $past(DATA_BUS_I))
		else $error("read data not captured");
	AST_WRITE_DRIVE:
		assert property (st == cbf_pkg::S_T1 && !ph && !DOUBLED_MODE_I && cur.wr
			|=> oe && dout == cur.wdata)
		else $error("write data not driven in t1 phase two");
	AST_WRITE_HOLD:
		assert property (done && cur.wr && !DOUBLED_MODE_I |=> oe && dout == $past(dout))
		else $error("write data hold lost");
	AST_WAIT_T2:
		assert property (st == cbf_pkg::S_T2 && e2 && !rdy && !na |=> st == cbf_pkg::S_T2)
		else $error("t2 wait state not repeated");
	AST_ADDR_STABLE:
		assert property (st == cbf_pkg::S_T2 |-> $stable(iss))
		else $error("address moved during t2");
	AST_T1P_IDLEWAIT:
		assert property (st == cbf_pkg::S_T1P && e2 && !f_valid |=>
			st == cbf_pkg::S_T2I && ads_n)
		else $error("t1p without request did not go t2i");
	AST_T2P_WAIT:
		assert property (st == cbf_pkg::S_T2P && e2 && !rdy |=> st == cbf_pkg::S_T2P && !ads_n)
		else $error("t2p wait state lost");
	AST_HOLD:
		assert property (st == cbf_pkg::S_HOLD |-> grant && ads_n)
		else $error("hold state without grant or with strobe");

	COV_PIPE: cover property (st == cbf_pkg::S_T2P ##1 st == cbf_pkg::S_T1P);
	COV_WAIT: cover property (st == cbf_pkg::S_T2 && e2 && !rdy);
	COV_T2I: cover property (st == cbf_pkg::S_T2I ##1 st == cbf_pkg::S_T2P);
	COV_HOLD: cover property (st == cbf_pkg::S_HOLD);
endmodule : cbf_bus_cycle

`default_nettype wire

// >>> bench/cbf_mem_model.sv
// partner model: memory and i/o decode logic answering the bus
`timescale 1ns/100ps
`default_nettype none
module cbf_mem_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ads_n_i,
	input wire logic [22:0] addr_i,
	input wire logic wr_i,
	input wire logic oe_i,
	input wire logic [15:0] dout_i,
	output logic ready_n_o,
	output logic na_n_o,
	output logic [15:0] drv_o
);
	int waits = 0; // wait states before ready
	bit na_on = 0; // ask for pipelining in each cycle
	bit early_rdy = 0; // ready also outside the acking state
	int acks = 0; // completed cycles
	int piped = 0; // addresses issued ahead of an ack
	int len = 0; // states in the last cycle
	int bad = 0; // float or address faults
	int wr_go = 0; // writes driven by end of first state
	int hold_ok = 0; // writes still driven in next phase one
	logic [15:0] last_wr; // data at a write ack
	cbf_pkg::cbf_req_t q[$]; // issued cycles, front is current
	cbf_pkg::cbf_req_t r; // last issued cycle
	logic ph, prev_ads, hold_chk, rdy, rd_drv;
	int idx; // state index in current cycle
	bit active;

	// ----------------------------------------------------------------
	// state tracking: first edge after reset ends phase one
	// ----------------------------------------------------------------
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ph = 1'b0;
			prev_ads = 1'b1;
			hold_chk = 1'b0;
			rdy = 1'b0;
			rd_drv = 1'b0;
			active = 0;
			idx = 0;
			q.delete();
			ready_n_o = 1'b1;
			na_n_o = 1'b1;
			drv_o = 16'h0;
		end
		else
		begin
			// write data must outlive phase one of the next state
			if (hold_chk && oe_i === 1'b1 && dout_i === last_wr)
				hold_ok++;
			hold_chk = 1'b0;
			if (ph)
			begin
				// a new address is a strobe after a state without one
				if (!ads_n_i && prev_ads)
				begin
					r = '{addr: addr_i, wr: wr_i, default: '0};
					if (active)
						piped++;
					q.push_back(r);
				end
				prev_ads = ads_n_i;
				if (!active && q.size() > 0)
				begin
					active = 1;
					idx = 0;
				end
				if (active)
				begin
					if (idx == 0 && q[0].wr && oe_i === 1'b1)
						wr_go++;
					if (!q[0].wr && oe_i !== 1'b0)
						bad++;
					if (q.size() == 1 && addr_i !== q[0].addr)
						bad++;
					// ready in the first state does not count
					if (rdy && idx >= 1)
					begin
						acks++;
						len = idx + 1;
						// only writes leave data to be held afterwards
						if (q[0].wr)
							last_wr = dout_i;
						hold_chk = q[0].wr;
						void'(q.pop_front());
						active = (q.size() > 0);
						idx = 0;
					end
					else
						idx++;
				end
			end
			ph = ~ph;
			#1;
			// answers change only at the start of a state
			if (!ph)
			begin
				rdy = active ? (idx == waits + 1 || (early_rdy && idx == 0)) : early_rdy;
				rd_drv = rdy && active && !q[0].wr;
				ready_n_o = ~rdy;
				na_n_o = ~(na_on && active);
			end
			// a released bus toggles so stale data never passes
			drv_o = rd_drv ? ~q[0].addr[15:0] : ~drv_o;
		end
	end
endmodule : cbf_mem_model
`default_nettype wire

// >>> bench/cbf_bus_cycle_tb_top.sv
// testbench top: sequencer against the memory model
`timescale 1ns/100ps
`default_nettype none
module cbf_bus_cycle_tb_top;
	logic clk, rst, hold, req_valid, req_ready, oe, ready_n, na_n, ads_n, grant, rvalid, wr;
	cbf_pkg::cbf_req_t req; // request offered
	logic [15:0] dout, rdata, mem_drv, bus;
	logic [22:0] addr;
	logic be_u, be_l, dc, mio; // definition pins beside the address
	int errors = 0;
	int num_checks = 0;
	int strobes = 0; // clocks with strobe low
	logic [15:0] rd_q[$]; // captured read data

	// data wire: the sequencer wins while it drives
	assign bus = oe ? dout : mem_drv;

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (rvalid === 1'b1)
			rd_q.push_back(rdata);
		if (ads_n === 1'b0)
			strobes++;
	end

	cbf_bus_cycle u_dut (.CLOCK_I(clk), .RST_I(rst), .DOUBLED_MODE_I(1'b0), .REQ_I(req),
		.REQ_VALID_I(req_valid), .REQ_READY_O(req_ready), .READY_N_I(ready_n),
		.NEXT_ADDRESS_REQUEST_N_I(na_n), .HOLD_I(hold), .DATA_BUS_I(bus), .DATA_BUS_O(dout),
		.DATA_BUS_OE_O(oe), .WORD_ADDRESS_O(addr), .UPPER_BYTE_ENABLE_N_O(be_u),
		.LOWER_BYTE_ENABLE_N_O(be_l), .WRITE_CYCLE_O(wr), .DATA_CYCLE_O(dc),
		.MEMORY_CYCLE_O(mio),
		.ADDRESS_STROBE_N_O(ads_n), .HOLD_GRANT_O(grant), .READ_DATA_O(rdata),
		.READ_DATA_VALID_O(rvalid));

	cbf_mem_model u_mem (.clk_i(clk), .rst_i(rst), .ads_n_i(ads_n), .addr_i(addr), .wr_i(wr),
		.oe_i(oe), .dout_i(dout), .ready_n_o(ready_n), .na_n_o(na_n), .drv_o(mem_drv));

	// ----------------------------------------------------------------
	// compare, handshake and wait helpers
	// ----------------------------------------------------------------
	task automatic chk_num(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : chk_num

	task automatic chk_rd(input logic [15:0] exp);
		logic [15:0] got;
		got = (rd_q.size() > 0) ? rd_q.pop_front() : 16'hxxxx;
		chk_num({16'h0, got}, {16'h0, exp}, "read data");
	endtask : chk_rd

	// valid stays up; the caller drops it after the last push
	task automatic push(input logic [22:0] a, input logic w, input logic [15:0] d);
		logic r;
		int k;
		k = 0;
		req = '{addr: a, wr: w, wdata: d, dc: 1'b1, mio: 1'b1, default: '0};
		req_valid = 1'b1;
		do
		begin
			@(negedge clk) r = req_ready;
			@(posedge clk);
			k++;
		end while (!r && k < 50);
		#1;
	endtask : push

	task automatic wait_acks(input int n);
		int k;
		k = 0;
		while (u_mem.acks < n && k < 400)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		chk_num(u_mem.acks, n, "ack count");
		repeat (2) @(posedge clk);
		#1;
	endtask : wait_acks

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_fast_read;
		int n;
		n = u_mem.acks;
		u_mem.early_rdy = 1;
		push(23'h12345, 1'b0, 16'h0);
		req_valid = 1'b0;
		wait_acks(n + 1);
		u_mem.early_rdy = 0;
		chk_num(u_mem.len, 2, "read length");
		chk_num(u_mem.r.addr, 23'h12345, "issued address");
		chk_num({be_u, be_l, dc, mio}, 32'h3, "definition pins");
		chk_rd(~16'h2345);
		$display("test fast_read done");
	endtask : t_fast_read

	task automatic t_write_wait;
		int n, g, h;
		n = u_mem.acks;
		g = u_mem.wr_go;
		h = u_mem.hold_ok;
		u_mem.waits = 2;
		push(23'h00abc, 1'b1, 16'hbeef);
		push(23'h00abd, 1'b0, 16'h0);
		req_valid = 1'b0;
		wait_acks(n + 2);
		chk_num(u_mem.wr_go - g, 1, "write drive start");
		chk_num(u_mem.hold_ok - h, 1, "write hold");
		chk_num(u_mem.last_wr, 16'hbeef, "write data");
		chk_num(u_mem.len, 4, "wait length");
		chk_rd(~16'h0abd);
		$display("test write_wait done");
	endtask : t_write_wait

	task automatic t_pipeline;
		int n, p, i;
		n = u_mem.acks;
		p = u_mem.piped;
		u_mem.waits = 1;
		u_mem.na_on = 1;
		for (i = 0; i < 3; i++)
			push(23'h200 + 23'(i), 1'b0, 16'h0);
		req_valid = 1'b0;
		wait_acks(n + 3);
		chk_num(u_mem.piped - p, 2, "pipelined issues");
		chk_num(u_mem.len, 3, "idle-wait length");
		for (i = 0; i < 3; i++)
			chk_rd(~(16'h0200 + 16'(i)));
		u_mem.na_on = 0;
		$display("test pipeline done");
	endtask : t_pipeline

	// idle, then hold while the request queue fills up
	task automatic t_hold;
		int n, s, k, i;
		logic r;
		n = u_mem.acks;
		s = strobes;
		repeat (20) @(posedge clk);
		#1;
		chk_num(strobes - s, 0, "idle strobe");
		hold = 1'b1;
		k = 0;
		while (grant !== 1'b1 && k < 20)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		chk_num(grant, 1, "hold grant");
		s = strobes;
		k = 0;
		req_valid = 1'b1;
		repeat (12)
		begin
			req = '{addr: 23'h300 + 23'(k), default: '0};
			@(negedge clk) r = req_ready;
			@(posedge clk);
			#1;
			if (r)
				k++;
		end
		req_valid = 1'b0;
		chk_num(k, 8, "queue depth");
		chk_num(strobes - s, 0, "strobe in hold");
		hold = 1'b0;
		wait_acks(n + 8);
		for (i = 0; i < 8; i++)
			chk_rd(~(16'h0300 + 16'(i)));
		$display("test hold_fill done");
	endtask : t_hold

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	initial
	begin
		#100000;
		errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		end_sim;
	end

	initial
	begin
		rst = 1'b1;
		hold = 1'b0;
		req_valid = 1'b0;
		req = '0;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		t_fast_read;
		t_write_wait;
		t_pipeline;
		t_hold;
		chk_num(u_mem.bad, 0, "float or address fault");
		end_sim;
	end
endmodule : cbf_bus_cycle_tb_top
`default_nettype wire
